// ===== rtl/itm_interval_timer.v
// Operation
// - With the gate off, writes other than to the gate register are ignored and the timer held reset.
// - Main source bit picks system clock at 0, internal oscillator at 1.
// - Source 00 sub clock, 01 low-speed oscillator plus wake-timer bit.
// - Sources 10 and 11 divide main clock by 1464, 976, 488 or 244.
// - Run bit 0 stops and clears the count; 1 starts it.
// - Interrupt every compare plus one count clocks; compare never zero (a written zero is accepted and matches on every count clock).
// - On match the count clears, keeps running and raises the interrupt.
// - Written run bit reads back one count clock later.
// - Interval interrupt keeps working in deep sleep to wake the chip; here all logic runs from clk, with no sleep mode or wake path.
`timescale 1ns/1ps
`include "itm_consts.vh"

module itm_interval_timer #(
    parameter CMP_WIDTH = 15
) (
    input wire clk,
    input wire sys_rst,
    input wire [31:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire sub_clock,
    input wire low_speed_osc_clock,
    input wire high_speed_sys_clock,
    input wire hoco_clock,
    input wire wake_timer_clock_bit,
    output reg interval_irq,
    output reg interval_irq_flag_out
);
    reg [7:0] peripheral_clock_enable_0_reg;
    reg [7:0] ccsel_reg;
    reg run_req_reg;
    reg [CMP_WIDTH-1:0] cmp_reg;
    reg stat_reg;
    reg mask_reg;
    reg ack_reg;
    reg [3:0] meta_reg;
    reg [3:0] sync_reg;
    reg [3:0] sync_d_reg;
    reg [10:0] div_reg;
    reg [10:0] div_limit;
    reg tick;
    wire gate;
    wire core_clear;
    wire run_seen;
    wire [CMP_WIDTH-1:0] count;
    wire match;
    wire main_sel;
    wire [1:0] src;
    wire main_edge;
    wire req;
    wire wr_ok;

    assign gate = peripheral_clock_enable_0_reg[`ITM_PERIPHERAL_CLOCK_ENABLE_0_GATE_BIT];
    assign main_sel = ccsel_reg[`ITM_CCSEL_MAIN_BIT];
    assign src = {ccsel_reg[`ITM_CCSEL_SRC_HI], ccsel_reg[`ITM_CCSEL_SRC_LO]};
    assign core_clear = sys_rst | ~gate;
    assign req = (avs_read | avs_write) & avs_waitrequest & ~ack_reg;
    // Writes land at the edge where the master sees waitrequest low
    assign wr_ok = avs_write & ack_reg;

    // Two-flop synchronisers for the external count sources
    always @(posedge clk) begin
        if (sys_rst) begin
            meta_reg <= 4'h0;
            sync_reg <= 4'h0;
            sync_d_reg <= 4'h0;
        end else begin
            meta_reg <= {hoco_clock, high_speed_sys_clock,
                         low_speed_osc_clock, sub_clock};
            sync_reg <= meta_reg;
            sync_d_reg <= sync_reg;
        end
    end

    // Main clock chosen by the source bit feeds the divider
    assign main_edge = main_sel ? (sync_reg[3] & ~sync_d_reg[3])
                                : (sync_reg[2] & ~sync_d_reg[2]);

    always @* begin
        case ({src[0], ccsel_reg[`ITM_CCSEL_DIV_BIT]})
            2'b00: div_limit = `ITM_DIV_1464;
            2'b01: div_limit = `ITM_DIV_976;
            2'b10: div_limit = `ITM_DIV_488;
            2'b11: div_limit = `ITM_DIV_244;
            default: div_limit = `ITM_DIV_1464;
        endcase
    end

    // Sources are only sampled: a main clock near clk would alias here
    always @(posedge clk) begin
        if (core_clear) begin
            div_reg <= 11'd0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            case (src)
                2'b00: tick <= sync_reg[0] & ~sync_d_reg[0];
                // Wake-timer clock bit must be set for this source
                2'b01: tick <= sync_reg[1] & ~sync_d_reg[1] &
                               wake_timer_clock_bit;
                default: begin
                    if (main_edge) begin
                        if (div_reg == div_limit - 11'd1) begin
                            div_reg <= 11'd0;
                            tick <= 1'b1;
                        end else begin
                            div_reg <= div_reg + 11'd1;
                        end
                    end
                end
            endcase
        end
    end

    itm_count_core #(
        .WIDTH(CMP_WIDTH)
    ) u_core (
        .clk(clk),
        .clear(core_clear),
        .tick(tick),
        .run_req(run_req_reg),
        .compare_value(cmp_reg),
        .run_seen(run_seen),
        .count(count),
        .match(match)
    );

    // Register file; only the gate register stays writable while gated
    always @(posedge clk) begin
        if (sys_rst) begin
            peripheral_clock_enable_0_reg <= `ITM_PERIPHERAL_CLOCK_ENABLE_0_RESET;
            ccsel_reg <= `ITM_CCSEL_RESET;
            run_req_reg <= 1'b0;
            cmp_reg <= `ITM_CMP_RESET;
            mask_reg <= 1'b1;
        end else begin
            if (wr_ok && avs_address == `ITM_ADDR_PERIPHERAL_CLOCK_ENABLE_0 && avs_byteenable[0]) begin
                peripheral_clock_enable_0_reg <= avs_writedata[7:0];
            end
            if (!gate) begin
                run_req_reg <= 1'b0;
                cmp_reg <= `ITM_CMP_RESET;
                ccsel_reg <= `ITM_CCSEL_RESET;
            end else if (wr_ok) begin
                if (avs_address == `ITM_ADDR_CCSEL && avs_byteenable[0]) begin
                    ccsel_reg <= avs_writedata[7:0] & `ITM_CCSEL_WMASK;
                end
                // 16-bit unit: both low lanes must be enabled
                if (avs_address == `ITM_ADDR_CTRL &&
                    avs_byteenable[1:0] == 2'b11) begin
                    run_req_reg <= avs_writedata[`ITM_CTRL_RUN_BIT];
                    cmp_reg <= avs_writedata[CMP_WIDTH-1:0];
                end
                if (avs_address == `ITM_ADDR_IRQ_MASK && avs_byteenable[0]) begin
                    mask_reg <= avs_writedata[0];
                end
            end
        end
    end

    // Sticky flag: a match in the clearing cycle wins
    always @(posedge clk) begin
        if (core_clear) begin
            stat_reg <= 1'b0;
        end else if (match) begin
            stat_reg <= 1'b1;
        end else if (wr_ok && avs_address == `ITM_ADDR_IRQ_STATUS &&
                     avs_byteenable[0] && avs_writedata[0]) begin
            stat_reg <= 1'b0;
        end
    end

    // Runs from clk alone, so it works only while clk runs; there is no deep-sleep wake path
    always @(posedge clk) begin
        if (sys_rst) begin
            interval_irq <= 1'b0;
            interval_irq_flag_out <= 1'b0;
        end else begin
            interval_irq <= stat_reg & ~mask_reg & ~match |
                            match & ~mask_reg;
            interval_irq_flag_out <= match;
        end
    end

    // Avalon slave: one wait cycle, then a single-cycle answer
    always @(posedge clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            ack_reg <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
            ack_reg <= 1'b0;
            if (req) begin
                avs_waitrequest <= 1'b0;
                ack_reg <= 1'b1;
                avs_readdata <= 32'h0000_0000;
                if (avs_read) begin
                    case (avs_address)
                        `ITM_ADDR_PERIPHERAL_CLOCK_ENABLE_0: avs_readdata <= {24'h0, peripheral_clock_enable_0_reg};
                        `ITM_ADDR_CCSEL: avs_readdata <= {24'h0, ccsel_reg};
                        `ITM_ADDR_CTRL: avs_readdata <=
                            {16'h0, run_seen, cmp_reg};
                        `ITM_ADDR_IRQ_STATUS: avs_readdata <=
                            {31'h0, stat_reg};
                        `ITM_ADDR_IRQ_MASK: avs_readdata <=
                            {31'h0, mask_reg};
                        default: avs_readdata <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end
endmodule

// ===== inc/itm_consts.vh
`ifndef ITM_CONSTS_VH
`define ITM_CONSTS_VH

`define ITM_ADDR_PERIPHERAL_CLOCK_ENABLE_0       32'h40020420
`define ITM_ADDR_CCSEL      32'h4002047C
`define ITM_ADDR_CTRL       32'h40044F50
`define ITM_ADDR_IRQ_STATUS 32'h40044F54
`define ITM_ADDR_IRQ_MASK   32'h40044F58

`define ITM_PERIPHERAL_CLOCK_ENABLE_0_GATE_BIT   7
`define ITM_CCSEL_MAIN_BIT  7
`define ITM_CCSEL_DIV_BIT   6
`define ITM_CCSEL_SRC_HI    1
`define ITM_CCSEL_SRC_LO    0
`define ITM_CTRL_RUN_BIT    15

`define ITM_PERIPHERAL_CLOCK_ENABLE_0_RESET      8'h00
`define ITM_CCSEL_RESET     8'h00
`define ITM_CMP_RESET       15'h7FFF
`define ITM_CCSEL_WMASK     8'hC3

`define ITM_DIV_1464        11'd1464
`define ITM_DIV_976         11'd976
`define ITM_DIV_488         11'd488
`define ITM_DIV_244         11'd244

`endif

// ===== rtl/itm_count_core.v
`timescale 1ns/1ps
`include "itm_consts.vh"

// Count-clock domain logic, advanced by a one-cycle tick enable.
module itm_count_core #(
    parameter WIDTH = 15
) (
    input wire clk,
    input wire clear,
    input wire tick,
    input wire run_req,
    input wire [WIDTH-1:0] compare_value,
    output reg run_seen,
    output reg [WIDTH-1:0] count,
    output reg match
);
    always @(posedge clk) begin
        if (clear) begin
            run_seen <= 1'b0;
            count <= {WIDTH{1'b0}};
            match <= 1'b0;
        end else begin
            match <= 1'b0;
            if (tick) begin
                // Run bit takes effect one count clock after the write
                run_seen <= run_req;
                if (!run_req) begin
                    count <= {WIDTH{1'b0}};
                end else if (run_seen && count == compare_value) begin
                    count <= {WIDTH{1'b0}};
                    match <= 1'b1;
                end else if (run_seen) begin
                    count <= count + 1'b1;
                end
            end
        end
    end
endmodule

// ===== tb/itm_props.sv
`timescale 1ns/1ps
`include "itm_consts.vh"
module itm_props (
    input wire clk,
    input wire sys_rst,
    input wire [31:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire sub_clock,
    input wire low_speed_osc_clock,
    input wire high_speed_sys_clock,
    input wire hoco_clock,
    input wire wake_timer_clock_bit,
    input wire interval_irq,
    input wire interval_irq_flag_out
);
    // Gate history, so stale pulses right after switching off are allowed
    reg [2:0] gate_reg;
    wire done = avs_write && !avs_waitrequest;
    always @(posedge clk) begin
        if (sys_rst) begin
            gate_reg <= 3'h0;
        end else begin
            gate_reg <= {gate_reg[1:0], gate_reg[0]};
            if (done && avs_address == `ITM_ADDR_PERIPHERAL_CLOCK_ENABLE_0) begin
                gate_reg[0] <= avs_writedata[7];
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_taken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_stop;
        s_taken ##0 (avs_write && avs_address == `ITM_ADDR_CTRL
            && !avs_writedata[15]);
    endsequence
    chk_wait_answer: assert property (s_taken |=> !avs_waitrequest)
        else $error("answer late");
    chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer too long");
    chk_reset_idle: assert property ($fell(sys_rst) |-> avs_waitrequest
        && !interval_irq && avs_readdata == 32'h0) else $error("reset state");
    chk_gate_quiet: assert property (gate_reg == 3'h0 |->
        !interval_irq_flag_out && !interval_irq) else $error("gated irq");
    chk_gated_ctrl: assert property (s_taken ##0 avs_read
        && avs_address == `ITM_ADDR_CTRL && !gate_reg[0]
        |=> avs_readdata[15:0] == 16'h7FFF) else $error("gated ctrl");
    chk_flag_pulse: assert property (interval_irq_flag_out
        |=> !interval_irq_flag_out) else $error("flag too long");
    chk_irq_cause: assert property ($rose(interval_irq) |->
        interval_irq_flag_out || $past(avs_write)
        || $past(avs_write, 2)) else $error("irq without cause");
    chk_stop_quiet: assert property (s_stop ##1 1'b1 ##2 1'b1 |->
        !interval_irq_flag_out [*8]) else $error("match after stop");
endmodule
bind itm_interval_timer itm_props u_props (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sub_clock(sub_clock), .low_speed_osc_clock(low_speed_osc_clock),
    .high_speed_sys_clock(high_speed_sys_clock), .hoco_clock(hoco_clock),
    .wake_timer_clock_bit(wake_timer_clock_bit),
    .interval_irq(interval_irq), .interval_irq_flag_out(interval_irq_flag_out));

// ===== tb/itm_interval_timer_bench.sv
`timescale 1ns/1ps
`include "itm_consts.vh"
module itm_interval_timer_bench;
    reg clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, wake_bit = 0;
    reg sub = 0, lso = 0, hsc = 0, hoco = 0;
    reg [31:0] avs_address = 0, avs_writedata = 0, q;
    reg [3:0] be = 4'hF;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, interval_irq, flag;
    integer fails = 0, checks = 0, cyc = 0, n, cmp, i;
    // Tick period of each count source in clk cycles, divider included
    integer per[6] = '{8, 10, 5856, 5856, 1952, 1464};
    reg [7:0] ccv[6] = '{8'h00, 8'h01, 8'h02, 8'hC2, 8'h03, 8'hC3};
    itm_interval_timer #(.CMP_WIDTH(15)) uut (.clk(clk), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(be), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sub_clock(sub),
        .low_speed_osc_clock(lso), .high_speed_sys_clock(hsc),
        .hoco_clock(hoco), .wake_timer_clock_bit(wake_bit),
        .interval_irq(interval_irq), .interval_irq_flag_out(flag));
    initial begin
        forever #20 clk = ~clk;
    end
    // Slow sources kept at least two clk high and low for the synchronizer
    always @(posedge clk) begin
        cyc <= cyc + 1;
        sub <= cyc % 8 < 4;
        lso <= cyc % 10 < 5;
        hsc <= cyc % 4 < 2;
        hoco <= cyc % 6 < 3;
        if (cyc == 90000) begin
            fails = fails + 1;
            end_sim;
        end
    end
    task end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task bus(input wr, input [31:0] a, input [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        q = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
        @(posedge clk);
    endtask
    task rd(input [31:0] a, input [31:0] e);
        bus(0, a, 0);
        chk(q, e);
    endtask
    task wflag;
        n = 0;
        @(posedge clk);
        while (flag !== 1'b1) begin
            n = n + 1;
            @(posedge clk);
        end
    endtask
    initial begin
        i = $urandom(97533);
        repeat (4) @(posedge clk);
        sys_rst <= 0;
        rd(`ITM_ADDR_PERIPHERAL_CLOCK_ENABLE_0, 0);
        bus(1, `ITM_ADDR_CTRL, 32'h8003);
        rd(`ITM_ADDR_CTRL, 32'h7FFF);
        rd(32'h40044F5C, 0);
        rd(`ITM_ADDR_IRQ_MASK, 1);
        bus(1, `ITM_ADDR_PERIPHERAL_CLOCK_ENABLE_0, 32'h80);
        rd(`ITM_ADDR_PERIPHERAL_CLOCK_ENABLE_0, 32'h80);
        $display("test 1 done");
        for (i = 0; i < 6; i = i + 1) begin
            wake_bit <= i == 1;
            bus(1, `ITM_ADDR_CCSEL, ccv[i]);
            rd(`ITM_ADDR_CCSEL, ccv[i]);
            cmp = i < 2 ? $urandom % 15 + 1 : 1;
            bus(1, `ITM_ADDR_CTRL, 32'h8000 | cmp);
            wflag;
            wflag;
            chk(n + 1, (cmp + 1) * per[i]);
            rd(`ITM_ADDR_CTRL, 32'h8000 | cmp);
            chk(interval_irq, 0);
            bus(1, `ITM_ADDR_CTRL, cmp);
        end
        $display("test 2 done");
        bus(1, `ITM_ADDR_CCSEL, 0);
        bus(1, `ITM_ADDR_CTRL, 32'h8002);
        wflag;
        bus(1, `ITM_ADDR_IRQ_STATUS, 1);
        bus(1, `ITM_ADDR_IRQ_MASK, 0);
        wflag;
        wflag;
        chk(n + 1, 24);
        @(posedge clk);
        chk(interval_irq, 1);
        rd(`ITM_ADDR_IRQ_STATUS, 1);
        bus(1, `ITM_ADDR_IRQ_MASK, 1);
        @(posedge clk);
        chk(interval_irq, 0);
        bus(1, `ITM_ADDR_CTRL, 2);
        bus(1, `ITM_ADDR_IRQ_STATUS, 1);
        rd(`ITM_ADDR_IRQ_STATUS, 0);
        be <= 4'h1;
        bus(1, `ITM_ADDR_CTRL, 32'h8005);
        be <= 4'hF;
        rd(`ITM_ADDR_CTRL, 32'h0002);
        bus(1, `ITM_ADDR_PERIPHERAL_CLOCK_ENABLE_0, 0);
        rd(`ITM_ADDR_CTRL, 32'h7FFF);
        rd(`ITM_ADDR_CCSEL, 0);
        $display("test 3 done");
        end_sim;
    end
endmodule
